//--- core/wdt_consts.vh
// Constants for the prescaled match watchdog timer
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH
`define WDT_CNT_W        32
`define WDT_CNT_ZERO     32'h00000000
`define WDT_CNT_ONE      32'h00000001
`define WDT_SYNC_STAGES  3
`define WDT_OUT_OFF      1'b0
`endif

//--- core/watchdog_prescaled_match_timer.v
// Watchdog timer: prescale divider, timer counter, two match comparators
`include "wdt_consts.vh"

// Behaviour
// - Each enabled edge advances a 32-bit prescale counter compared to its value.
// - On a prescale match the divider clears and the timer counter steps.
// - The timer steps once every prescale value plus one enabled edges.
// - The timer count is compared against match value 0 and match value 1.
// - A timer match on value 0 raises the match-zero event.
// - A timer match on value 1 raises the reset request.
// - The clock and reset unit keeps a flag for a reset from this block.
// - With the reset action off the counters serve as an ordinary timer.
module watchdog_prescaled_match_timer (
  // Clock, reset, clock enable
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clk_en,
  // Control from the chip side, same clock domain
  input  wire        enable,
  input  wire        reset_action_en,
  input  wire        reload,
  input  wire [31:0] prescale_value,
  input  wire [31:0] match_zero_value,
  input  wire [31:0] match_one_value,
  // Status
  output reg  [31:0] prescale_count,
  output reg  [31:0] timer_count,
  // Toward event router and clock/reset unit
  output reg         match_zero_event,
  output reg         match_one_reset_request
);

  // Step kinds, decoded once per edge
  localparam [1:0] STEP_HOLD   = 2'b00;
  localparam [1:0] STEP_COUNT  = 2'b01;
  localparam [1:0] STEP_CLEAR  = 2'b10;
  localparam [1:0] STEP_FREEZE = 2'b11;

  // Decoded step and compare results
  reg  [1:0]  step;
  reg         prescale_hit;
  reg         zero_hit;
  reg         one_hit;

  // Incremented counts
  reg  [31:0] prescale_plus_one;
  reg  [31:0] timer_plus_one;

  // Next values of every register
  reg  [31:0] next_prescale_count;
  reg  [31:0] next_timer_count;
  reg         next_match_zero_event;
  reg         next_match_one_reset_request;

  // Reload outranks counting so a late kick still restarts the interval
  always @* begin
    if (!clk_en) begin
      step = STEP_FREEZE;
    end else if (reload) begin
      step = STEP_CLEAR;
    end else if (enable) begin
      step = STEP_COUNT;
    end else begin
      step = STEP_HOLD;
    end
  end

  // Incrementers; the carry out is dropped on purpose so counts wrap
  always @* begin
    prescale_plus_one = prescale_count + `WDT_CNT_ONE;
    timer_plus_one    = timer_count + `WDT_CNT_ONE;
  end

  // Divider compare is plain equality: a value below the count wraps
  // through the full 32-bit range rather than stalling
  always @* begin
    prescale_hit = (prescale_count == prescale_value);
  end

  // Next prescale count: clear on reload or on a divider match
  always @* begin
    case (step)
      STEP_CLEAR: begin
        next_prescale_count = `WDT_CNT_ZERO;
      end
      STEP_COUNT: begin
        if (prescale_hit) begin
          next_prescale_count = `WDT_CNT_ZERO;
        end else begin
          next_prescale_count = prescale_plus_one;
        end
      end
      STEP_HOLD: begin
        next_prescale_count = prescale_count;
      end
      default: begin
        next_prescale_count = prescale_count;
      end
    endcase
  end

  // Next timer count: one step per full divider period
  always @* begin
    case (step)
      STEP_CLEAR: begin
        next_timer_count = `WDT_CNT_ZERO;
      end
      STEP_COUNT: begin
        if (prescale_hit) begin
          next_timer_count = timer_plus_one;
        end else begin
          next_timer_count = timer_count;
        end
      end
      STEP_HOLD: begin
        next_timer_count = timer_count;
      end
      default: begin
        next_timer_count = timer_count;
      end
    endcase
  end

  // Compare against the next count so a match rises on the same edge
  // as the count it belongs to, with no cycle of lag
  always @* begin
    zero_hit = (next_timer_count == match_zero_value);
    one_hit  = (next_timer_count == match_one_value);
  end

  // Match levels; a reload or a stopped timer drops both, a frozen
  // clock enable holds both
  always @* begin
    case (step)
      STEP_COUNT: begin
        next_match_zero_event = zero_hit;
        // Gate keeps the block usable as a plain timer
        next_match_one_reset_request = one_hit && reset_action_en;
      end
      STEP_FREEZE: begin
        next_match_zero_event        = match_zero_event;
        next_match_one_reset_request = match_one_reset_request;
      end
      STEP_CLEAR: begin
        next_match_zero_event        = `WDT_OUT_OFF;
        next_match_one_reset_request = `WDT_OUT_OFF;
      end
      default: begin
        next_match_zero_event        = `WDT_OUT_OFF;
        next_match_one_reset_request = `WDT_OUT_OFF;
      end
    endcase
  end

  // Prescale counter register; chip reset outranks the clock enable
  always @(posedge clk) begin
    if (!rst_n) begin
      prescale_count <= `WDT_CNT_ZERO;
    end else begin
      prescale_count <= next_prescale_count;
    end
  end

  // Timer counter register
  always @(posedge clk) begin
    if (!rst_n) begin
      timer_count <= `WDT_CNT_ZERO;
    end else begin
      timer_count <= next_timer_count;
    end
  end

  // Event toward the event router, which may make it an interrupt
  always @(posedge clk) begin
    if (!rst_n) begin
      match_zero_event <= `WDT_OUT_OFF;
    end else begin
      match_zero_event <= next_match_zero_event;
    end
  end

  // Request toward the clock and reset unit, which also latches it as
  // the reset cause; the level stands until the count or match value moves on, reset_action_en drops, or the timer stops or reloads
  always @(posedge clk) begin
    if (!rst_n) begin
      match_one_reset_request <= `WDT_OUT_OFF;
    end else begin
      match_one_reset_request <= next_match_one_reset_request;
    end
  end

endmodule // watchdog_prescaled_match_timer

//--- verif/wdt_sva.sv
// Checker on the watchdog timer ports
module wdt_sva (input wire clk, rst_n, clk_en, enable, reset_action_en,
  input wire reload, input wire [31:0] prescale_value, match_zero_value,
  input wire [31:0] match_one_value, prescale_count, timer_count,
  input wire match_zero_event, match_one_reset_request);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Enabled edge on which the counters may move
  sequence s_count_edge;
    clk_en && enable && !reload;
  endsequence
  a_prescale_clear: assert property (s_count_edge ##0
    prescale_count == prescale_value |=> prescale_count == 0)
    else $error("prescale clear");
  a_freeze_hold: assert property (!clk_en |=>
    $stable(prescale_count) && $stable(timer_count) &&
    $stable(match_zero_event) && $stable(match_one_reset_request))
    else $error("freeze");
  a_idle_quiet: assert property (clk_en && !enable && !reload |=>
    $stable(timer_count) && !match_zero_event && !match_one_reset_request)
    else $error("idle");
  a_reload_clears: assert property (clk_en && reload |=>
    prescale_count == 0 && timer_count == 0) else $error("reload");
  a_timer_step: assert property (clk_en && enable && !reload &&
    prescale_count == prescale_value |=> timer_count ==
    $past(timer_count) + 1) else $error("step");
  a_zero_event: assert property (clk_en && enable && !reload |=>
    match_zero_event == (timer_count == $past(match_zero_value)))
    else $error("match zero");
  a_one_request: assert property (clk_en && enable && !reload |=>
    match_one_reset_request == ($past(reset_action_en) &&
    timer_count == $past(match_one_value))) else $error("match one");
endmodule // wdt_sva
bind watchdog_prescaled_match_timer wdt_sva u_sva (.*);

//--- verif/clock_reset_unit.sv
// Clock and reset unit model keeping the watchdog reset cause
module clock_reset_unit (input wire clk, input wire match_one_reset_request,
  output logic wdt_flag);
  timeunit 1ns; timeprecision 1ps;
  // Flag is never cleared by chip reset, so the cause stays readable
  always @(posedge clk) if (match_one_reset_request) wdt_flag <= 1'b1;
  initial wdt_flag = 1'b0;
endmodule // clock_reset_unit

//--- verif/watchdog_prescaled_match_timer_tb_top.sv
// Random self-checking bench for the watchdog timer
module watchdog_prescaled_match_timer_tb_top;
  timeunit 1ns; timeprecision 1ps;
  logic clk = 0, rst_n = 0, ce = 1, en = 1, ra = 1, rl = 1, mz, mo, ez, eo;
  logic wf, ef = 0;
  logic [31:0] pv = 32'h1, m0, m1, pc, tc, ep = 0, et = 0, r = 32'h31F4;
  int n_errors = 0, total_checks = 0;
  initial forever #12.5 clk = ~clk;
  watchdog_prescaled_match_timer dut (.clk(clk), .rst_n(rst_n), .clk_en(ce),
    .enable(en), .reset_action_en(ra), .reload(rl), .prescale_value(pv),
    .match_zero_value(m0), .match_one_value(m1), .prescale_count(pc),
    .timer_count(tc), .match_zero_event(mz), .match_one_reset_request(mo));
  clock_reset_unit cru (.clk(clk), .match_one_reset_request(mo), .wdt_flag(wf));
  // Next state of the stimulus generator
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Level a match output should show after an enabled edge
  function automatic logic hit(input logic e, l, input logic [31:0] t, m);
    return e && !l && t == m;
  endfunction
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog: the run needs about 3000 cycles
  initial begin #100000; n_errors++; report_and_stop; end
  initial begin
    {ez, eo, m0, m1} = 0;
    repeat (12) @(negedge clk);
    rst_n = 1;
    // Divider only changes on reload, else the count could run past it
    for (int i = 0; i < 3000; i++) begin
      r = lfsr(r);
      // Frequent reloads keep the dog fed
      {rl, ce, en, ra} = {r[4:0] == 0, r[7:5] != 0, r[10:8] != 0, r[11]};
      {m0, m1} = {28'h0, r[15:12], 28'h0, r[19:16]};
      if (i < 24) begin
        // Corner: divide by one, event at 3, request at 5, no freezes
        {rl, ce, en, ra} = {i == 0, 3'b111};
        {m0, m1} = {32'h3, 32'h5};
      end
      rst_n = (i != 1500);
      if (rl) pv = (i % 7 == 0) ? 32'h0 : {30'h0, r[21:20]};
      if (!rst_n) {ep, et, ez, eo} = 0;
      else if (ce) begin
        if (rl) {ep, et} = 0;
        else if (en) {ep, et} = (ep == pv) ? {32'h0, et + 32'h1}
          : {ep + 32'h1, et};
        ez = hit(en, rl, et, m0);
        eo = ra && hit(en, rl, et, m1);
      end
      @(negedge clk);
      total_checks++;
      if (wf !== ef) begin
        n_errors++;
        $display("mismatch at %0t: reset cause flag", $time);
      end
      ef = ef | eo;
      total_checks++;
      if ({pc, tc, mz, mo} !== {ep, et, ez, eo}) begin
        n_errors++;
        $display("mismatch at %0t: count or match output", $time);
      end
    end
    $display("random test done");
    report_and_stop;
  end
endmodule // watchdog_prescaled_match_timer_tb_top
